// file: cas_pkg.sv
// Purpose: shared constants and types for the cell alert status summary block
// Assumes: apb register bus, 32-bit data, one aligned word per register
// Notes:   offsets are byte addresses
package cas_pkg;

  // ----------------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------------
  localparam logic [7:0] ADDR_ALERT_STATUS = 8'h00;
  localparam logic [7:0] ADDR_SCAN_CTRL    = 8'h04;
  localparam logic [7:0] ADDR_MSMTCH_THR   = 8'h08;
  localparam logic [7:0] ADDR_IRQ_STATUS   = 8'h0c;
  localparam logic [7:0] ADDR_IRQ_MASK     = 8'h10;

  // ----------------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------------
  localparam int BIT_SCAN_ALERT   = 15;
  localparam int BIT_RESET_ALERT  = 14;
  localparam int BIT_MSMTCH_ALERT = 13;
  localparam int BIT_OVER_SUM     = 12;
  localparam int BIT_UNDER_SUM    = 11;
  localparam int BIT_SCAN_REQ     = 0;
  localparam int BIT_SCAN_DONE    = 1;
  localparam int IRQ_SCAN         = 0;
  localparam int IRQ_MSMTCH       = 1;
  localparam int IRQ_OVER         = 2;
  localparam int IRQ_UNDER        = 3;
  localparam int IRQ_RESET        = 4;
  localparam int IRQ_W            = 5;
  localparam int CELLS            = 14;

  // ----------------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------------
  localparam logic              RESET_ALERT_RST = 1'b1;
  localparam logic [15:0]       MSMTCH_THR_RST  = 16'h0100;
  localparam logic [IRQ_W-1:0]  IRQ_MASK_RST    = 5'h00;
  localparam logic [IRQ_W-1:0]  IRQ_STATUS_RST  = 5'h10;

  // ----------------------------------------------------------------------
  // types
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [CELLS:1] adc_cell_over_flags;
    logic [CELLS:1] comparator_cell_over_flags;
    logic [CELLS:1] adc_cell_under_flags;
    logic [CELLS:1] comparator_cell_under_flags;
  } cas_cell_flags_t;

  typedef struct packed {
    logic [15:0] vmax;
    logic [15:0] vmin;
  } cas_extremes_t;

  typedef enum logic [1:0] {
    SCAN_IDLE,
    SCAN_BUSY,
    SCAN_DONE
  } cas_scan_state_t;

endpackage : cas_pkg

// file: cas_sum_bit.sv
// Purpose: summary alert bit, set from any flag, removed at acquisition
// Assumes: acq is a one-cycle pulse from the measurement engines
// Notes:   a flag present in the acquisition cycle keeps the bit set
`timescale 1ns/10ps
`default_nettype none
module cas_sum_bit #(
  parameter int W = 28
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] flags,
  input  wire logic         acq,
  output var  logic         sum_q
);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sum_q <= 1'b0;
    end else if (|flags) begin
      sum_q <= 1'b1;
    end else if (acq) begin
      sum_q <= 1'b0;
    end
  end

endmodule : cas_sum_bit
`default_nettype wire

// file: cas_irq.sv
// Purpose: sticky interrupt status with mask and level output
// Assumes: clr comes from the cycle in which a read captures the status
// Notes:   a new event in the clearing cycle survives the clear
`timescale 1ns/10ps
`default_nettype none
module cas_irq #(
  parameter int               W   = 5,
  parameter logic [W-1:0]     RST = '0
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] events,
  input  wire logic [W-1:0] mask,
  input  wire logic         clr,
  output var  logic [W-1:0] status_q,
  output var  logic         irq_q
);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      status_q <= RST;
    end else begin
      status_q <= (clr ? '0 : status_q) | events;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(status_q & mask);
    end
  end

endmodule : cas_irq
`default_nettype wire

// file: cas_alert_status.sv
// Purpose: device alert status register, bits 15 to 11, behind an apb slave
// Assumes: measurement engines deliver flags, extremes and an acquisition pulse
// Notes:   bits 10 to 0 of the alert status read as zero in this block
//
// Register access over APB and the placing of the registers were decided locally.
`timescale 1ns/10ps
`default_nettype none

// How it works
// - reset alert set by power-on reset; write zero clears, write one ignored
// - mismatch alert set when highest minus lowest cell exceeds threshold
// - overvoltage summary is OR of all adc and comparator cell over flags
// - overvoltage summary removed only at acquisition once resolved; not writable
// - undervoltage summary is OR of all adc and comparator cell under flags
module cas_alert_status (
  input  wire logic                     pclk,
  input  wire logic                     presetn,
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [7:0]               paddr,
  input  wire logic [31:0]              pwdata,
  input  wire logic [3:0]               pstrb,
  output var  logic [31:0]              prdata,
  output var  logic                     pready,
  output var  logic                     pslverr,
  input  wire cas_pkg::cas_cell_flags_t cell_flags,
  input  wire cas_pkg::cas_extremes_t   extremes,
  input  wire logic                     acq_valid,
  output var  logic                     scan_start,
  output var  logic [15:0]              device_alert_status,
  output var  logic                     irq
);

  // ----------------------------------------------------------------------
  // bus slave
  // ----------------------------------------------------------------------
  logic                          pready_q;
  logic                          pslverr_q;
  logic [31:0]                   prdata_q;
  logic                          access;
  logic                          done;
  logic                          wr;
  logic                          hit;
  logic [31:0]                   rd_d;
  logic                          reset_alert_q;
  logic                          msmtch_q;
  logic                          over_q;
  logic                          under_q;
  logic [15:0]                   thr_q;
  logic [cas_pkg::IRQ_W-1:0]     mask_q;
  logic [cas_pkg::IRQ_W-1:0]     irq_status;
  logic [cas_pkg::IRQ_W-1:0]     events;
  logic                          irq_q;
  logic                          scan_start_q;
  logic [15:0]                   status_q;
  logic [15:0]                   status_d;
  logic                          scan_complete_flag;
  logic                          reset_clr;
  logic                          rd_irq;
  logic                          msmtch_now;
  logic                          over_any;
  logic                          under_any;
  logic                          over_prev_q;
  logic                          under_prev_q;
  logic                          msmtch_prev_q;
  logic                          scan_prev_q;
  cas_pkg::cas_scan_state_t      scan_state_q;

  // one wait state: pready rises in the second access cycle, so read data
  // comes from a register and no combinational path reaches the bus
  assign access = psel & penable & ~pready_q;
  assign done   = psel & penable & pready_q;
  assign wr     = done & pwrite;

  always_comb begin
    hit  = 1'b1;
    rd_d = 32'h0000_0000;
    if (paddr == cas_pkg::ADDR_ALERT_STATUS) begin
      rd_d[15:0] = status_d;
    end else if (paddr == cas_pkg::ADDR_SCAN_CTRL) begin
      rd_d[cas_pkg::BIT_SCAN_REQ]  = (scan_state_q == cas_pkg::SCAN_BUSY);
      rd_d[cas_pkg::BIT_SCAN_DONE] = scan_complete_flag;
    end else if (paddr == cas_pkg::ADDR_MSMTCH_THR) begin
      rd_d[15:0] = thr_q;
    end else if (paddr == cas_pkg::ADDR_IRQ_STATUS) begin
      rd_d[cas_pkg::IRQ_W-1:0] = irq_status;
    end else if (paddr == cas_pkg::ADDR_IRQ_MASK) begin
      rd_d[cas_pkg::IRQ_W-1:0] = mask_q;
    end else begin
      hit = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
    end else begin
      pready_q  <= access;
      pslverr_q <= access & ~hit;
      if (access && !pwrite) begin
        prdata_q <= rd_d;
      end
    end
  end

  assign prdata  = prdata_q;
  assign pready  = pready_q;
  assign pslverr = pslverr_q;

  // ----------------------------------------------------------------------
  // software controls
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      thr_q <= cas_pkg::MSMTCH_THR_RST;
    end else if (wr && paddr == cas_pkg::ADDR_MSMTCH_THR) begin
      if (pstrb[0]) begin
        thr_q[7:0] <= pwdata[7:0];
      end
      if (pstrb[1]) begin
        thr_q[15:8] <= pwdata[15:8];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_q <= cas_pkg::IRQ_MASK_RST;
    end else if (wr && paddr == cas_pkg::ADDR_IRQ_MASK && pstrb[0]) begin
      mask_q <= pwdata[cas_pkg::IRQ_W-1:0];
    end
  end

  // ----------------------------------------------------------------------
  // scan control
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scan_state_q <= cas_pkg::SCAN_IDLE;
      scan_start_q <= 1'b0;
    end else begin
      scan_start_q <= 1'b0;
      case (scan_state_q)
        cas_pkg::SCAN_IDLE: begin
          if (wr && paddr == cas_pkg::ADDR_SCAN_CTRL && pwdata[cas_pkg::BIT_SCAN_REQ]) begin
            scan_state_q <= cas_pkg::SCAN_BUSY;
            scan_start_q <= 1'b1;
          end
        end
        cas_pkg::SCAN_BUSY: begin
          if (acq_valid) begin
            scan_state_q <= cas_pkg::SCAN_DONE;
          end
        end
        cas_pkg::SCAN_DONE: begin
          if (wr && paddr == cas_pkg::ADDR_SCAN_CTRL && pwdata[cas_pkg::BIT_SCAN_REQ]) begin
            scan_state_q <= cas_pkg::SCAN_BUSY;
            scan_start_q <= 1'b1;
          end else if (wr && paddr == cas_pkg::ADDR_SCAN_CTRL
                       && !pwdata[cas_pkg::BIT_SCAN_DONE]) begin
            scan_state_q <= cas_pkg::SCAN_IDLE;
          end
        end
        default: begin
          scan_state_q <= cas_pkg::SCAN_IDLE;
        end
      endcase
    end
  end

  // the scan alert has no storage of its own, so it cannot disagree
  assign scan_complete_flag = (scan_state_q == cas_pkg::SCAN_DONE);

  // ----------------------------------------------------------------------
  // alert bits
  // ----------------------------------------------------------------------
  assign reset_clr = wr && paddr == cas_pkg::ADDR_ALERT_STATUS && pstrb[1]
                     && !pwdata[cas_pkg::BIT_RESET_ALERT];

  // presetn stands for the power-on reset; nothing else sets the bit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reset_alert_q <= cas_pkg::RESET_ALERT_RST;
    end else if (reset_clr) begin
      reset_alert_q <= 1'b0;
    end
  end

  // the difference is only formed when the extremes are ordered
  assign msmtch_now = (extremes.vmax > extremes.vmin)
                      && ((extremes.vmax - extremes.vmin) > thr_q);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      msmtch_q <= 1'b0;
    end else if (acq_valid) begin
      msmtch_q <= msmtch_now;
    end
  end

  assign over_any  = |{cell_flags.adc_cell_over_flags, cell_flags.comparator_cell_over_flags};
  assign under_any = |{cell_flags.adc_cell_under_flags,
                       cell_flags.comparator_cell_under_flags};

  // software writes never reach these two instances
  cas_sum_bit #(.W(2*cas_pkg::CELLS)) u_over_sum (
    .clk   (pclk),
    .rst_n (presetn),
    .flags ({cell_flags.adc_cell_over_flags, cell_flags.comparator_cell_over_flags}),
    .acq   (acq_valid),
    .sum_q (over_q)
  );

  cas_sum_bit #(.W(2*cas_pkg::CELLS)) u_under_sum (
    .clk   (pclk),
    .rst_n (presetn),
    .flags ({cell_flags.adc_cell_under_flags, cell_flags.comparator_cell_under_flags}),
    .acq   (acq_valid),
    .sum_q (under_q)
  );

  always_comb begin
    status_d                            = 16'h0000;
    status_d[cas_pkg::BIT_SCAN_ALERT]   = scan_complete_flag;
    status_d[cas_pkg::BIT_RESET_ALERT]  = reset_alert_q;
    status_d[cas_pkg::BIT_MSMTCH_ALERT] = msmtch_q;
    status_d[cas_pkg::BIT_OVER_SUM]     = over_q;
    status_d[cas_pkg::BIT_UNDER_SUM]    = under_q;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_q <= 16'h4000;
    end else begin
      status_q <= status_d;
    end
  end

  assign device_alert_status = status_q;
  assign scan_start          = scan_start_q;

  // ----------------------------------------------------------------------
  // interrupts
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      over_prev_q   <= 1'b0;
      under_prev_q  <= 1'b0;
      msmtch_prev_q <= 1'b0;
      scan_prev_q   <= 1'b0;
    end else begin
      over_prev_q   <= over_q;
      under_prev_q  <= under_q;
      msmtch_prev_q <= msmtch_q;
      scan_prev_q   <= scan_complete_flag;
    end
  end

  always_comb begin
    events                      = '0;
    events[cas_pkg::IRQ_SCAN]   = scan_complete_flag & ~scan_prev_q;
    events[cas_pkg::IRQ_MSMTCH] = msmtch_q & ~msmtch_prev_q;
    events[cas_pkg::IRQ_OVER]   = over_q & ~over_prev_q;
    events[cas_pkg::IRQ_UNDER]  = under_q & ~under_prev_q;
    events[cas_pkg::IRQ_RESET]  = 1'b0;
  end

  // clear in the cycle in which read data is captured, so an event landing between
  // capture and completion is kept for the next read instead of being lost
  assign rd_irq = access & ~pwrite & (paddr == cas_pkg::ADDR_IRQ_STATUS);

  cas_irq #(.W(cas_pkg::IRQ_W), .RST(cas_pkg::IRQ_STATUS_RST)) u_irq (
    .clk      (pclk),
    .rst_n    (presetn),
    .events   (events),
    .mask     (mask_q),
    .clr      (rd_irq),
    .status_q (irq_status),
    .irq_q    (irq_q)
  );

  assign irq = irq_q;

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  a_reset_alert_clear: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(reset_alert_q) |-> $past(reset_clr))
    else $error("reset alert fell without a write of zero");

  a_reset_alert_w1: assert property (@(posedge pclk) disable iff (!presetn)
    (wr && paddr == cas_pkg::ADDR_ALERT_STATUS && pwdata[cas_pkg::BIT_RESET_ALERT])
    |=> $stable(reset_alert_q))
    else $error("write of one changed the reset alert");

  a_mismatch_set: assert property (@(posedge pclk) disable iff (!presetn)
    (acq_valid && msmtch_now) |=> msmtch_q ##1 status_q[cas_pkg::BIT_MSMTCH_ALERT])
    else $error("mismatch alert missing after acquisition");

  a_over_or: assert property (@(posedge pclk) disable iff (!presetn)
    over_any |=> over_q ##1 status_q[cas_pkg::BIT_OVER_SUM])
    else $error("overvoltage summary missed a cell flag");

  a_over_hold: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(over_q) |-> $past(acq_valid) && !$past(over_any))
    else $error("overvoltage summary removed outside a clean acquisition");

  a_under_or: assert property (@(posedge pclk) disable iff (!presetn)
    under_any |=> under_q ##1 status_q[cas_pkg::BIT_UNDER_SUM])
    else $error("undervoltage summary missed a cell flag");

  a_scan_copy: assert property (@(posedge pclk) disable iff (!presetn)
    (scan_state_q == cas_pkg::SCAN_BUSY && acq_valid)
    |=> scan_complete_flag ##1 status_q[cas_pkg::BIT_SCAN_ALERT])
    else $error("scan alert did not follow completion");

  a_scan_busy_zero: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(scan_start_q) |-> !status_d[cas_pkg::BIT_SCAN_ALERT])
    else $error("scan alert set while a scan runs");

endmodule : cas_alert_status
`default_nettype wire

// file: tb_top.sv
// Purpose: self-checking bench for the cell alert status block
// Assumes: apb master timing, slave answers with its own pready
// Notes:   random flags and extremes from a fixed seed, corner cases among them
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  // ----------------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------------
  logic                     pclk, presetn, psel, penable, pwrite, acq_valid;
  logic [7:0]               paddr;
  logic [31:0]              pwdata, prdata, rd;
  logic [3:0]               pstrb;
  logic                     pready, pslverr, scan_start, irq, err;
  logic [15:0]              das, thr, vmin, vmax;
  logic [55:0]              f;
  cas_pkg::cas_cell_flags_t cell_flags;
  cas_pkg::cas_extremes_t   extremes;
  int                       mismatches, checks_done;
  int                       starts = 0;

  cas_alert_status dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cell_flags(cell_flags), .extremes(extremes),
    .acq_valid(acq_valid), .scan_start(scan_start), .device_alert_status(das), .irq(irq)
  );

  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  always @(posedge pclk) begin
    if (scan_start === 1'b1) starts <= starts + 1;
  end

  // ----------------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // request held until pready is seen high at a rising edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] s);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 4'hf);
  endtask : wr

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0, 4'h0);
    chk(rd, exp);
  endtask : rdchk

  // let the edge's own updates land before looking
  task automatic settle(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask : settle

  task automatic acq;
    @(posedge pclk);
    acq_valid <= 1'b1;
    @(posedge pclk);
    acq_valid <= 1'b0;
    settle(4);
  endtask : acq

  function automatic logic mm_exp(input logic [15:0] hi, lo, t);
    return (hi > lo) && ((hi - lo) > t);
  endfunction : mm_exp

  task automatic finish_test;
    if (mismatches == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : finish_test

  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial begin
    {presetn, psel, penable, pwrite, acq_valid} = 5'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    pstrb = 4'h0;
    cell_flags = '0;
    extremes = '0;
    void'($urandom(32'h8a05));
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    settle(1);
    chk({16'h0, das}, 32'h4000);
    rdchk(cas_pkg::ADDR_ALERT_STATUS, 32'h4000);
    rdchk(cas_pkg::ADDR_IRQ_STATUS, 32'h10);
    rdchk(cas_pkg::ADDR_IRQ_STATUS, 32'h0);
    // writing ones changes nothing, read-only bits ignore writes
    wr(cas_pkg::ADDR_ALERT_STATUS, 32'hffff);
    rdchk(cas_pkg::ADDR_ALERT_STATUS, 32'h4000);
    apb(1'b1, cas_pkg::ADDR_ALERT_STATUS, 32'h0, 4'h1);
    rdchk(cas_pkg::ADDR_ALERT_STATUS, 32'h4000);
    // masked under event, unmasked over event
    wr(cas_pkg::ADDR_IRQ_MASK, 32'h04);
    cell_flags <= cas_pkg::cas_cell_flags_t'(56'h1);
    settle(4);
    chk({31'h0, irq}, 32'h0);
    @(posedge pclk);
    cell_flags <= cas_pkg::cas_cell_flags_t'(56'h1 << 55);
    settle(4);
    chk({31'h0, irq}, 32'h1);
    wr(cas_pkg::ADDR_ALERT_STATUS, 32'h0);
    settle(3);
    chk({16'h0, das}, 32'h1800);
    acq;
    chk({16'h0, das}, 32'h1000);
    @(posedge pclk);
    cell_flags <= '0;
    settle(3);
    chk({16'h0, das}, 32'h1000);
    acq;
    chk({16'h0, das}, 32'h0);
    rdchk(cas_pkg::ADDR_IRQ_STATUS, 32'h0c);
    settle(3);
    chk({31'h0, irq}, 32'h0);
    wr(cas_pkg::ADDR_IRQ_MASK, 32'h0);
    // random flag patterns: set, held without acquisition, removed at acquisition
    for (int i = 0; i < 40; i++) begin
      if (i % 3 == 0) f = 56'({$urandom, $urandom} & {$urandom, $urandom});
      else f = 56'h1 << $urandom_range(55, 0);
      @(posedge pclk);
      cell_flags <= cas_pkg::cas_cell_flags_t'(f);
      settle(3);
      chk({30'h0, das[12:11]}, {30'h0, |f[55:28], |f[27:0]});
      @(posedge pclk);
      cell_flags <= '0;
      settle(3);
      chk({30'h0, das[12:11]}, {30'h0, |f[55:28], |f[27:0]});
      acq;
      chk({30'h0, das[12:11]}, 32'h0);
    end
    chk({31'h0, irq}, 32'h0);
    // mismatch threshold boundaries
    rdchk(cas_pkg::ADDR_MSMTCH_THR, 32'h0100);
    apb(1'b0, cas_pkg::ADDR_IRQ_STATUS, 32'h0, 4'h0);
    wr(cas_pkg::ADDR_IRQ_MASK, 32'h02);
    for (int i = 0; i < 8; i++) begin
      thr = 16'($urandom_range(16'h3fff, 1));
      vmin = 16'($urandom_range(16'h3fff, 0));
      case (i % 4)
        0: vmax = vmin + thr + 16'h1;
        1: vmax = vmin + thr;
        2: vmax = 16'($urandom);
        default: begin
          vmax = vmin;
          vmin = vmax + thr + 16'h2;
        end
      endcase
      wr(cas_pkg::ADDR_MSMTCH_THR, {16'h0, thr});
      extremes <= {vmax, vmin};
      acq;
      chk({31'h0, das[13]}, {31'h0, mm_exp(vmax, vmin, thr)});
      if (i == 0) chk({31'h0, irq}, 32'h1);
    end
    @(posedge pclk);
    extremes <= '0;
    // scan done alert follows the scan state
    wr(cas_pkg::ADDR_SCAN_CTRL, 32'h1);
    settle(2);
    chk(32'(starts), 32'h1);
    rdchk(cas_pkg::ADDR_SCAN_CTRL, 32'h1);
    chk({31'h0, das[15]}, 32'h0);
    acq;
    chk({31'h0, das[15]}, 32'h1);
    rdchk(cas_pkg::ADDR_SCAN_CTRL, 32'h2);
    wr(cas_pkg::ADDR_SCAN_CTRL, 32'h0);
    settle(3);
    chk({31'h0, das[15]}, 32'h0);
    // unmapped address is refused
    apb(1'b1, 8'h14, 32'hffff, 4'hf);
    chk({31'h0, err}, 32'h1);
    apb(1'b0, 8'h14, 32'h0, 4'h0);
    chk({31'h0, err}, 32'h1);
    chk(rd, 32'h0);
    // a second reset raises the reset alert again
    @(posedge pclk);
    presetn <= 1'b0;
    settle(2);
    chk({16'h0, das}, 32'h4000);
    @(posedge pclk);
    presetn <= 1'b1;
    settle(2);
    rdchk(cas_pkg::ADDR_ALERT_STATUS, 32'h4000);
    finish_test();
  end

  // the whole sequence needs under a thousand cycles
  initial begin
    repeat (20000) @(posedge pclk);
    mismatches++;
    finish_test();
  end
endmodule : tb_top
`default_nettype wire
